// ==== pkg/hpc_cfg.svh ====
// Constants for the host port and control pin block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define HPC_NUM_OUT 7
`define HPC_NUM_GATE 3
`define HPC_STAT_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HPC_MASK0_RST 7'h7f
`define HPC_MASK12_RST 7'h00
`define HPC_SPI4_RST 1'h1

// ----------------------------------------------------------------
// Internal pull levels seen when a pin floats
// ----------------------------------------------------------------
`define HPC_PULL_SEL 1'h1
`define HPC_PULL_CS 1'h1
`define HPC_PULL_RST 1'h1
`define HPC_PULL_GATE 1'h0

`endif

// ==== pkg/hpc_pkg.sv ====
// Types shared by the host port and control pin block.
// Assumes the constant header sits beside this file.
`include "hpc_cfg.svh"

package hpc_pkg;

  // ----------------------------------------------------------------
  // Host port mode, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HPC_I2C = 3'h1,
    HPC_SPI3 = 3'h2,
    HPC_SPI4 = 3'h4
  } hpc_mode_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Pulled input pin: level plus pad report that nobody drives it
  typedef struct packed {
    logic val;
    logic undriven;
  } hpc_pin_s;

  // Transmit request from the serial engine, link clock domain
  typedef struct packed {
    logic pull_low;
    logic spi_bit;
    logic spi_drive;
  } hpc_tx_s;

endpackage : hpc_pkg

// ==== hdl/hpc_sync2.sv ====
// Two flip-flop synchroniser for levels.
// Assumes the input is quasi-static or a level from another domain.
`timescale 1ns/10ps

module hpc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : hpc_sync2

// ==== hdl/hpc_out_gate.sv ====
// Clock output gating from three enable pins through per-pin masks.
// Assumes gate levels are already synchronised, active high = asserted.
`timescale 1ns/10ps
`include "hpc_cfg.svh"

module hpc_out_gate
  import hpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate pins and masks
  input wire logic [`HPC_NUM_GATE-1:0] gate_act,
  input wire logic [`HPC_NUM_GATE-1:0][`HPC_NUM_OUT-1:0] mask,
  // Output enables
  output logic [`HPC_NUM_OUT-1:0] en_r
);

  logic [`HPC_NUM_OUT-1:0] blocked;

  // Any masked gate pin that is deasserted blocks the output
  for (genvar i = 0; i < `HPC_NUM_OUT; i++) begin : g_out
    wire [`HPC_NUM_GATE-1:0] col;
    for (genvar g = 0; g < `HPC_NUM_GATE; g++) begin : g_col
      assign col[g] = mask[g][i];
    end
    assign blocked[i] = |(col & ~gate_act);
  end

  // Outputs held off during reset
  always_ff @(posedge clk) begin
    if (rst) begin
      en_r <= '0;
    end else begin
      en_r <= ~blocked;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gate_blocks: assert property (@(posedge clk) disable iff (rst)
    !gate_act[0] |=> ((en_r & $past(mask[0])) == '0))
    else $error("output on while its gate pin is off");

  a_gate_all_on: assert property (@(posedge clk) disable iff (rst)
    (&gate_act) |=> (&en_r))
    else $error("output off while all gate pins are on");

  c_gate_partial: cover property (@(posedge clk) disable iff (rst)
    (en_r != '0) && (en_r != '1));

endmodule : hpc_out_gate

// ==== hdl/hpc_top.sv ====
// Host serial port pin mux and global control pins of a clock device.
// Assumes a serial engine on the link clock and status from the core.
//
// Operation
// - Strap high selects I2C host port, strap low selects SPI.
// - Floating interface strap reads high, giving I2C.
// - Data pin is SDA in I2C, SDIO in 3-wire, input in 4-wire.
// - Second pin is plain address input in I2C, SDO in 4-wire SPI.
// - Third pin is low address in I2C, active-low select in SPI.
// - Select pin pulled high so a floating select leaves device deselected.
// - Interrupt output goes low when device status changes.
// - Reset pin low returns logic and registers to defaults.
// - Clock outputs stay disabled while reset is active; reset pin pulled high.
// - Each of three gate pins controls a programmable subset of outputs.
// - After reset gate 0 controls all outputs, gates 1 and 2 none.
// - Gate pins pulled low so a floating gate enables its outputs.
`timescale 1ns/10ps
`include "hpc_cfg.svh"

module hpc_top
  import hpc_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link clock from the host
  input wire logic sclk,
  // Pulled control pins
  input wire hpc_pin_s iface_sel,
  input wire hpc_pin_s addr_low_or_select_n,
  input wire hpc_pin_s device_reset_n,
  input wire hpc_pin_s output_gate_0_n,
  input wire hpc_pin_s output_gate_1_n,
  input wire hpc_pin_s output_gate_2_n,
  // Shared data pin
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe_n,
  // Address high or serial out pin
  input wire logic addr_high_or_spi_out_i,
  output logic addr_high_or_spi_out_o,
  output logic addr_high_or_spi_out_oe_n,
  // Serial engine, link clock domain
  input wire hpc_tx_s link_tx,
  output logic link_rst_r,
  output hpc_mode_e link_mode_r,
  output logic link_rx_data_r,
  output logic link_select_n_r,
  // Configuration
  input wire logic spi_4wire_cfg,
  input wire logic mask_wr,
  input wire logic [1:0] mask_sel,
  input wire logic [`HPC_NUM_OUT-1:0] mask_data,
  // Status and interrupt
  input wire logic [`HPC_STAT_W-1:0] status_in,
  input wire logic irq_ack,
  output logic status_change_irq_n,
  // Core controls
  output hpc_mode_e mode_r,
  output logic [1:0] addr_sel_r,
  output logic device_rst_r,
  output logic [`HPC_NUM_OUT-1:0] clk_out_en_r
);

  // ----------------------------------------------------------------
  // Pad pull resolution
  // ----------------------------------------------------------------
  wire sel_lvl;
  wire cs_lvl;
  wire rst_lvl;
  wire [`HPC_NUM_GATE-1:0] gate_lvl;

  // A floating pin reads its internal pull level
  assign sel_lvl = iface_sel.undriven ? `HPC_PULL_SEL : iface_sel.val;
  assign cs_lvl = addr_low_or_select_n.undriven ? `HPC_PULL_CS
                                                : addr_low_or_select_n.val;
  assign rst_lvl = device_reset_n.undriven ? `HPC_PULL_RST : device_reset_n.val;
  assign gate_lvl[0] = output_gate_0_n.undriven ? `HPC_PULL_GATE : output_gate_0_n.val;
  assign gate_lvl[1] = output_gate_1_n.undriven ? `HPC_PULL_GATE : output_gate_1_n.val;
  assign gate_lvl[2] = output_gate_2_n.undriven ? `HPC_PULL_GATE : output_gate_2_n.val;

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  logic rst_pin_act;
  wire dev_rst;

  // Reset pin crosses in before use; sys_rst alone clears the sync
  hpc_sync2 #(.W(1), .RST_VAL(1'h1)) u_rst_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(~rst_lvl),
    .q(rst_pin_act)
  );

  assign dev_rst = sys_rst | rst_pin_act;

  // Reset copy for the rest of the core
  always_ff @(posedge clk) begin
    device_rst_r <= dev_rst;
  end

  // ----------------------------------------------------------------
  // Strap capture and mode
  // ----------------------------------------------------------------
  logic sel_sync;
  logic strap_r;
  logic spi4_r;
  hpc_mode_e mode_nxt;

  // Left out of reset: a reset sync would feed its reset value into the capture
  hpc_sync2 #(.W(1), .RST_VAL(1'h1)) u_sel_sync (
    .clk(clk),
    .rst(1'h0),
    .d(sel_lvl),
    .q(sel_sync)
  );

  // Strap caught while reset holds, frozen once released
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      strap_r <= sel_sync;
      spi4_r <= `HPC_SPI4_RST;
    end else begin
      spi4_r <= spi_4wire_cfg;
    end
  end

  // SPI flavour never looks at the strap
  assign mode_nxt = strap_r ? HPC_I2C : (spi4_r ? HPC_SPI4 : HPC_SPI3);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= HPC_I2C;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // I2C address straps
  // ----------------------------------------------------------------
  logic [1:0] addr_sync;

  // High address pin has no pull: the raw level is taken as is
  hpc_sync2 #(.W(2), .RST_VAL(2'h0)) u_addr_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({addr_high_or_spi_out_i, cs_lvl}),
    .q(addr_sync)
  );

  // Address only meaningful in I2C; reads zero in SPI
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      addr_sel_r <= 2'h0;
    end else begin
      addr_sel_r <= (mode_r == HPC_I2C) ? addr_sync : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Output gate masks
  // ----------------------------------------------------------------
  logic [`HPC_NUM_GATE-1:0][`HPC_NUM_OUT-1:0] mask_r;
  logic [`HPC_NUM_GATE-1:0] gate_act;

  // Written masks return to defaults on any reset
  for (genvar g = 0; g < `HPC_NUM_GATE; g++) begin : g_mask
    wire hit;
    assign hit = mask_wr && (mask_sel == 2'(g));
    always_ff @(posedge clk) begin
      if (dev_rst) begin
        mask_r[g] <= (g == 0) ? `HPC_MASK0_RST : `HPC_MASK12_RST;
      end else if (hit) begin
        mask_r[g] <= mask_data;
      end
    end
  end

  // Gate pins are asynchronous; two flops before the gate logic
  hpc_sync2 #(.W(`HPC_NUM_GATE), .RST_VAL(3'h0)) u_gate_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(~gate_lvl),
    .q(gate_act)
  );

  hpc_out_gate u_gate (
    .clk(clk),
    .rst(dev_rst),
    .gate_act(gate_act),
    .mask(mask_r),
    .en_r(clk_out_en_r)
  );

  // ----------------------------------------------------------------
  // Status change interrupt
  // ----------------------------------------------------------------
  logic [`HPC_STAT_W-1:0] stat_d_r;
  logic armed_r;
  logic irq_n_nxt;
  wire stat_chg;

  // First cycle after reset only samples, so no spurious event
  assign stat_chg = armed_r && (status_in != stat_d_r);

  // A change in the ack cycle wins over the ack
  assign irq_n_nxt = stat_chg ? 1'h0 : (irq_ack ? 1'h1 : status_change_irq_n);

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      stat_d_r <= '0;
      armed_r <= 1'h0;
      status_change_irq_n <= 1'h1;
    end else begin
      stat_d_r <= status_in;
      armed_r <= 1'h1;
      status_change_irq_n <= irq_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  logic [2:0] lmode_sync;
  logic lrst_sync;

  // Engine transfers run on the host clock; it must toggle during reset
  hpc_sync2 #(.W(1), .RST_VAL(1'h1)) u_lrst_sync (
    .clk(sclk),
    .rst(1'h0),
    .d(dev_rst),
    .q(lrst_sync)
  );

  // Mode changes outside reset only with spi_4wire_cfg, so a level crossing is enough
  hpc_sync2 #(.W(3), .RST_VAL(3'h1)) u_lmode_sync (
    .clk(sclk),
    .rst(lrst_sync),
    .d(mode_r),
    .q(lmode_sync)
  );

  hpc_sync2 #(.W(1), .RST_VAL(1'h1)) u_lsel_sync (
    .clk(sclk),
    .rst(lrst_sync),
    .d(cs_lvl),
    .q(link_select_n_r)
  );

  hpc_sync2 #(.W(1), .RST_VAL(1'h1)) u_ldat_sync (
    .clk(sclk),
    .rst(lrst_sync),
    .d(data_pin_i),
    .q(link_rx_data_r)
  );

  // Registered copies handed to the engine
  always_ff @(posedge sclk) begin
    link_rst_r <= lrst_sync;
    link_mode_r <= hpc_mode_e'(lmode_sync);
  end

  // ----------------------------------------------------------------
  // Pad drive, launched on the falling serial clock edge
  // ----------------------------------------------------------------
  logic dat_o_nxt;
  logic dat_oe_n_nxt;
  logic sdo_oe_n_nxt;
  wire selected;

  assign selected = ~link_select_n_r;

  // Data pin direction per mode
  always_comb begin
    dat_o_nxt = 1'h1;
    dat_oe_n_nxt = 1'h1;
    unique case (link_mode_r)
      HPC_I2C: begin
        dat_o_nxt = 1'h0;
        dat_oe_n_nxt = ~link_tx.pull_low;
      end
      HPC_SPI3: begin
        dat_o_nxt = link_tx.spi_bit;
        dat_oe_n_nxt = ~(selected & link_tx.spi_drive);
      end
      HPC_SPI4: begin
        dat_oe_n_nxt = 1'h1;
      end
      default: begin
        dat_oe_n_nxt = 1'h1;
      end
    endcase
  end

  // Serial out drives only while selected in 4-wire mode
  assign sdo_oe_n_nxt = ~((link_mode_r == HPC_SPI4) & selected);

  always_ff @(negedge sclk) begin
    if (link_rst_r) begin
      data_pin_o <= 1'h1;
      data_pin_oe_n <= 1'h1;
      addr_high_or_spi_out_o <= 1'h1;
      addr_high_or_spi_out_oe_n <= 1'h1;
    end else begin
      data_pin_o <= dat_o_nxt;
      data_pin_oe_n <= dat_oe_n_nxt;
      addr_high_or_spi_out_o <= link_tx.spi_bit;
      addr_high_or_spi_out_oe_n <= sdo_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks, system domain
  // ----------------------------------------------------------------
  a_strap_i2c_mode: assert property (@(posedge clk) disable iff (sys_rst)
    (!dev_rst && strap_r) |=> (mode_r == HPC_I2C))
    else $error("strap high but mode is not I2C");

  a_strap_float_high: assert property (@(posedge clk) disable iff (sys_rst)
    iface_sel.undriven |-> sel_lvl)
    else $error("floating strap did not read high");

  a_select_pull_up: assert property (@(posedge clk) disable iff (sys_rst)
    (addr_low_or_select_n.undriven [*3]) |-> addr_sync[0])
    else $error("floating select did not read high");

  a_irq_on_change: assert property (@(posedge clk) disable iff (dev_rst)
    stat_chg |=> !status_change_irq_n)
    else $error("status change did not pull interrupt low");

  a_irq_holds: assert property (@(posedge clk) disable iff (dev_rst)
    (!status_change_irq_n && !irq_ack) |=> !status_change_irq_n)
    else $error("interrupt released without ack");

  a_reset_masks: assert property (@(posedge clk) disable iff (sys_rst)
    rst_pin_act |=> (mask_r[0] == `HPC_MASK0_RST) && (mask_r[1] == '0) && (mask_r[2] == '0))
    else $error("masks not at defaults after reset");

  a_outputs_off_rst: assert property (@(posedge clk)
    dev_rst |=> (clk_out_en_r == '0))
    else $error("clock output on during reset");

  a_gate_float_on: assert property (@(posedge clk) disable iff (dev_rst)
    (output_gate_0_n.undriven [*3]) |-> gate_act[0])
    else $error("floating gate pin not asserted");

  a_mode_spi_cfg: assert property (@(posedge clk) disable iff (dev_rst)
    (!strap_r && spi4_r) |=> (mode_r == HPC_SPI4))
    else $error("4-wire setting not applied");

  // ----------------------------------------------------------------
  // Checks, link domain; interrupt cover on the system clock
  // ----------------------------------------------------------------
  a_spi4_data_input: assert property (@(negedge sclk) disable iff (link_rst_r)
    (link_mode_r == HPC_SPI4) |=> data_pin_oe_n)
    else $error("data pin driven in 4-wire mode");

  a_sdo_off_i2c: assert property (@(negedge sclk) disable iff (link_rst_r)
    (link_mode_r == HPC_I2C) |=> addr_high_or_spi_out_oe_n)
    else $error("address pin driven in I2C mode");

  a_spi3_drive: assert property (@(negedge sclk) disable iff (link_rst_r)
    ((link_mode_r == HPC_SPI3) && selected && link_tx.spi_drive) |=> !data_pin_oe_n)
    else $error("3-wire data not driven when requested");

  c_i2c_pull: cover property (@(negedge sclk) disable iff (link_rst_r)
    (link_mode_r == HPC_I2C) ##1 !data_pin_oe_n);
  c_spi4_out: cover property (@(negedge sclk) disable iff (link_rst_r)
    !addr_high_or_spi_out_oe_n);
  c_irq_event: cover property (@(posedge clk) disable iff (dev_rst)
    stat_chg ##1 irq_ack);

endmodule : hpc_top

// ==== sim/hpc_host_model.sv ====
// Host controller stand-in: link clock, select pin and host data drive.
// Assumes the bench opens and closes frames through run and sel_act.
`timescale 1ns/10ps

module hpc_host_model
  import hpc_pkg::*;
(
  // Frame control from the bench
  input wire logic run,
  input wire logic sel_act,
  input wire logic host_oe,
  input wire logic host_bit,
  // Device drive of the shared data pin
  input wire logic dev_oe_n,
  input wire logic dev_bit,
  // Pins seen by the device
  output logic sclk,
  output hpc_pin_s select_pin,
  output logic data_level
);
  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // Stands high between frames, 64 ns period inside them
  // Fractional start offset keeps link edges off the system clock grid
  initial begin
    sclk = 1'b1;
    #0.3;
    forever begin
      #32;
      sclk = run ? ~sclk : 1'b1;
    end
  end

  // Idle select floats, so only the device pull-up holds it high
  assign select_pin = sel_act ? 2'h0 : 2'h1;

  // Wire level: device drive, else host drive, else the board pull-up
  assign data_level = !dev_oe_n ? dev_bit : (host_oe ? host_bit : 1'b1);
endmodule : hpc_host_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the host port and control pin block.
// Assumes the host stand-in model and all design files are compiled first.
`timescale 1ns/10ps

module tb_top
  import hpc_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b1, sel_act = 1'b0, host_oe = 1'b0, host_bit = 1'b1;
  logic sclk, data_level, addr_hi = 1'b0;
  hpc_pin_s strap = 2'h1, sel_pin, rst_pin = 2'h1, g0 = 2'h1, g1 = 2'h1, g2 = 2'h1;
  hpc_tx_s tx = '0;
  logic spi4 = 1'b1, mask_wr = 1'b0, ack = 1'b0;
  logic [1:0] mask_sel = 2'h0;
  logic [6:0] mask_data = 7'h00;
  logic [7:0] status = 8'h00;
  logic d_o, d_oe_n, a_o, a_oe_n, l_rst, l_rx, l_sel_n, irq_n, dev_rst;
  hpc_mode_e l_mode, mode;
  logic [1:0] addr_sel;
  logic [6:0] en;
  logic [2:0][6:0] mask_m;
  logic b;
  int err_total = 0, cmp_count = 0;
  typedef struct {int kind; logic [7:0] v;} hpc_note_s;
  hpc_note_s notes[$];
  event look;
  string nm[13] = '{"en", "irq_n", "mode", "dev_rst", "d_oe_n", "sdo_oe_n", "l_sel_n", "addr_sel", "sdo",
    "l_mode", "d_o", "l_rx", "l_rst"};

  always #12.5 clk = ~clk;

  hpc_top uut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .iface_sel(strap), .addr_low_or_select_n(sel_pin),
    .device_reset_n(rst_pin), .output_gate_0_n(g0), .output_gate_1_n(g1), .output_gate_2_n(g2),
    .data_pin_i(data_level), .data_pin_o(d_o), .data_pin_oe_n(d_oe_n), .addr_high_or_spi_out_i(addr_hi),
    .addr_high_or_spi_out_o(a_o), .addr_high_or_spi_out_oe_n(a_oe_n), .link_tx(tx), .link_rst_r(l_rst),
    .link_mode_r(l_mode), .link_rx_data_r(l_rx), .link_select_n_r(l_sel_n), .spi_4wire_cfg(spi4),
    .mask_wr(mask_wr), .mask_sel(mask_sel), .mask_data(mask_data), .status_in(status), .irq_ack(ack),
    .status_change_irq_n(irq_n), .mode_r(mode), .addr_sel_r(addr_sel), .device_rst_r(dev_rst),
    .clk_out_en_r(en));

  hpc_host_model host (.run(run), .sel_act(sel_act), .host_oe(host_oe), .host_bit(host_bit),
    .dev_oe_n(d_oe_n), .dev_bit(d_o), .sclk(sclk), .select_pin(sel_pin), .data_level(data_level));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Drivers note the expectation; the watcher below does the compare
  task automatic note(input int kind, input logic [7:0] v);
    notes.push_back('{kind, v});
    ->look;
    #1;
  endtask : note

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] obs);
    cmp_count++;
    if (obs !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, obs);
    end
  endtask : cmp

  task automatic close_out();
    $display("Counts: %0d mismatches in %0d comparisons", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Long enough for several link clock edges, which the link flops need
  task automatic do_reset(input hpc_pin_s s);
    run = 1'b1;
    strap = s;
    sys_rst = 1'b1;
    mask_m = {7'h00, 7'h00, 7'h7f};
    cyc(16);
    note(0, 8'h00);
    note(3, 8'h01);
    note(1, 8'h01);
    note(12, 8'h01);
    sys_rst = 1'b0;
    cyc(24);
    note(12, 8'h00);
  endtask : do_reset

  task automatic set_mask(input logic [1:0] sel, input logic [6:0] d);
    mask_sel = sel;
    mask_data = d;
    mask_wr = 1'b1;
    if (sel != 2'h3) begin
      mask_m[sel] = d;
    end
    cyc(1);
    mask_wr = 1'b0;
  endtask : set_mask

  // Outputs stay enabled unless a deasserted gate masks them
  function automatic logic [6:0] exp_en();
    logic [2:0] act;
    logic [6:0] e;
    act = {~g2.val | g2.undriven, ~g1.val | g1.undriven, ~g0.val | g0.undriven};
    e = 7'h7f;
    for (int g = 0; g < 3; g++) begin
      if (!act[g]) begin
        e = e & ~mask_m[g];
      end
    end
    return e;
  endfunction : exp_en

  // ----------------------------------------------------------------
  // Watcher: oldest note against the output it names
  // ----------------------------------------------------------------
  always begin
    hpc_note_s n;
    logic [7:0] obs;
    @(look);
    n = notes.pop_front();
    case (n.kind)
      0: obs = {1'b0, en};
      1: obs = {7'h0, irq_n};
      2: obs = {5'h0, mode};
      3: obs = {7'h0, dev_rst};
      4: obs = {7'h0, d_oe_n};
      5: obs = {7'h0, a_oe_n};
      6: obs = {7'h0, l_sel_n};
      7: obs = {6'h0, addr_sel};
      8: obs = {7'h0, a_o};
      9: obs = {5'h0, l_mode};
      10: obs = {7'h0, d_o};
      11: obs = {7'h0, l_rx};
      default: obs = {7'h0, l_rst};
    endcase
    cmp(nm[n.kind], n.v, obs);
  end

  // Whole run is some 6.3 us; a hang is cut well past that
  initial begin
    #200us;
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(46));
    cyc(1);
    do_reset(2'h1);
    note(2, {5'h0, HPC_I2C});
    note(9, {5'h0, HPC_I2C});
    note(0, 8'h7f);
    addr_hi = 1'b1;
    cyc(6);
    note(7, 8'h03);
    sel_act = 1'b1;
    tx.pull_low = 1'b1;
    cyc(8);
    note(7, 8'h02);
    note(4, 8'h00);
    note(10, 8'h00);
    note(5, 8'h01);
    tx.pull_low = 1'b0;
    sel_act = 1'b0;
    cyc(8);
    note(4, 8'h01);
    run = 1'b0;
    // Gate 0 owns every output after reset, the others none
    g0 = 2'h2;
    cyc(4);
    note(0, 8'h00);
    g0 = 2'h1;
    g1 = 2'h2;
    g2 = 2'h2;
    cyc(4);
    note(0, 8'h7f);
    for (int i = 0; i < 10; i++) begin
      set_mask(2'($urandom_range(0, 3)), 7'($urandom));
      {g0, g1, g2} = 6'($urandom);
      cyc(4);
      note(0, {1'b0, exp_en()});
    end
    set_mask(2'h1, 7'h7f);
    // Status change raises the interrupt; a clear in a change cycle loses
    status = ~status;
    cyc(2);
    note(1, 8'h00);
    ack = 1'b1;
    status = status + 8'($urandom_range(1, 255));
    cyc(1);
    ack = 1'b0;
    cyc(2);
    note(1, 8'h00);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(2);
    note(1, 8'h01);
    // Reset pin clears masks back to default and blocks all outputs
    g0 = 2'h1;
    g1 = 2'h2;
    g2 = 2'h2;
    rst_pin = 2'h0;
    cyc(6);
    note(0, 8'h00);
    note(3, 8'h01);
    rst_pin = 2'h1;
    mask_m = {7'h00, 7'h00, 7'h7f};
    cyc(8);
    note(3, 8'h00);
    note(0, 8'h7f);
    // SPI, 4-wire by configuration
    spi4 = 1'b1;
    do_reset(2'h0);
    note(2, {5'h0, HPC_SPI4});
    b = 1'($urandom);
    tx = '{pull_low: 1'b0, spi_bit: b, spi_drive: 1'b1};
    sel_act = 1'b1;
    cyc(12);
    note(6, 8'h00);
    note(5, 8'h00);
    note(8, {7'h0, b});
    note(4, 8'h01);
    sel_act = 1'b0;
    cyc(12);
    note(6, 8'h01);
    note(5, 8'h01);
    // Switch to 3-wire while deselected
    spi4 = 1'b0;
    cyc(16);
    note(2, {5'h0, HPC_SPI3});
    note(9, {5'h0, HPC_SPI3});
    sel_act = 1'b1;
    cyc(12);
    note(4, 8'h00);
    note(10, {7'h0, b});
    tx.spi_drive = 1'b0;
    host_oe = 1'b1;
    host_bit = ~b;
    cyc(12);
    note(4, 8'h01);
    note(11, {7'h0, ~b});
    sel_act = 1'b0;
    host_oe = 1'b0;
    cyc(4);
    close_out();
  end
endmodule : tb_top
